// ===== hw/broc_cfg.svh
// offsets, fields, codes and timing counts of the radio operation control
`ifndef BROC_CFG_SVH
`define BROC_CFG_SVH
`define BROC_A_CTRL 8'h00
`define BROC_A_PARAM 8'h04
`define BROC_A_SEED 8'h08
`define BROC_A_AAW 8'h0C
`define BROC_A_RXCFG 8'h10
`define BROC_A_START 8'h14
`define BROC_A_LIMIT 8'h18
`define BROC_A_STAT 8'h1C
`define BROC_A_INFO 8'h20
`define BROC_C_SUBMIT 0
`define BROC_C_ABORT 1
`define BROC_C_STOP 2
`define BROC_C_SETUP 3
`define BROC_C_SYNTH 4
`define BROC_PARAM_RST 32'h0000_0000
`define BROC_RXCFG_RST 32'h011F_2500
`define BROC_S_IDLE 16'h0000
`define BROC_S_PEND 16'h0001
`define BROC_S_ACTIVE 16'h0002
`define BROC_S_OK 16'h1400
`define BROC_S_RXTO 16'h1401
`define BROC_S_NOSYNC 16'h1402
`define BROC_S_RXERR 16'h1403
`define BROC_S_ENDED 16'h1406
`define BROC_S_ABORT 16'h1407
`define BROC_S_STOPPED 16'h1408
`define BROC_S_PAR 16'h1800
`define BROC_S_NOSETUP 16'h1802
`define BROC_S_NOFS 16'h1803
`define BROC_S_SYNTH 16'h1804
`define BROC_S_RXOVF 16'h1805
`define BROC_S_TXUNF 16'h1806
`define BROC_DATA_MAX 8'h24
`define BROC_ADV_MIN 8'h25
`define BROC_ADV_MAX 8'h27
`define BROC_DIR_MIN 8'h3C
`define BROC_DIR_MAX 8'hCF
`define BROC_KEEP_CH 8'hFF
`define BROC_RF_BASE 12'h8FC
`define BROC_WH_BASE 7'h40
`define BROC_CLK_NS 50
`define BROC_IFS_NS 150000
`define BROC_EARLY_NS 2000
`define BROC_RXTO_NS 40000
`define BROC_IFS_CYC (`BROC_IFS_NS / `BROC_CLK_NS)
`define BROC_EARLY_CYC (`BROC_EARLY_NS / `BROC_CLK_NS)
`define BROC_OPEN_CYC (`BROC_IFS_CYC - `BROC_EARLY_CYC)
`define BROC_RXTO_CYC (`BROC_RXTO_NS / `BROC_CLK_NS)
`endif

// ===== hw/broc_pkg.sv
// types of the radio operation control
package broc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_PEND, ST_CHECK, ST_PROG, ST_LOAD,
        ST_RX, ST_RXEND, ST_TURNTX, ST_TX, ST_TURNRX, ST_DONE
    } broc_state_e;
    typedef struct packed {
        logic sync;
        logic [7:0] len;
        logic done;
        logic crcOk;
        logic seqBit;
        logic bufFits;
    } broc_rx_s;
    typedef struct packed {
        logic txDone;
        logic synthRunning;
        logic synthFail;
        logic genErr;
        logic rxOverflow;
        logic txUnderflow;
        logic startEvt;
        logic endEvt;
    } broc_evt_s;
    typedef struct packed {
        logic [11:0] freqMhz;
        logic [7:0] chanIdx;
        logic directFreq;
        logic [6:0] whitenSeed;
        logic whitenEn;
    } broc_rf_s;
endpackage : broc_pkg

// ===== hw/broc_top.sv
// radio operation control: command sequencing, channel, whitening, flags
// Operation
// - no prior setup: end with not-configured
// - configure radio only at start condition
// - indexes: connection 0-36, advertising 37-39
// - values 60-207 mean frequency 2300+value MHz
// - 255 keeps synth; error if not running
// - no override, index: seed 0x40 or channel
// - otherwise seed from init; zero disables
// - append and check CRC, seed per command
// - time turnarounds to spacing, tight window
// - slave first receive timeout gives timeout code
// - set flags, copy to status, interrupt
// - overlong length aborts as no sync; here a slave's first receive ends with the timeout code
// - auto-flush by flag before interrupting; flush and interrupt rise in the same cycle here
// - pending while waiting, active while running
// - normal completion codes 0x1400-0x1408
// - error completion codes 0x1800-0x1806
// - general error ends with abort code
// - trigger, frequency, address, seed, then radio
// - store into first fitting buffer
// - flags from CRC and sequence repetition
// - zero payload is empty, flushable
// - compare sequence bit with stored last
// - two CRC errors in a row end
`timescale 1ns/1ps
`include "broc_cfg.svh"
module broc_top
    import broc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // radio datapath events
    input wire broc_rx_s rxIn,
    input wire broc_evt_s evtIn,
    // radio controls
    output logic rxEn,
    output logic txEn,
    output logic crcEnable,
    output logic synthProgram,
    output logic loadLink,
    output broc_rf_s rfOut,
    output logic [23:0] crcSeedOut,
    output logic [31:0] accessWordOut,
    // receive entry handling and operation done
    output logic storeEntry,
    output logic flushEntry,
    output logic [7:0] statusByte,
    output logic rxIrq,
    output logic cmdDone
);
    logic rstMeta_q, rstSync_q, rst;
    broc_state_e state_q;
    logic [31:0] param_q, seed_q, aaw_q, rxcfg_q, start_q, limit_q;
    logic [31:0] timeNow_q, waitCnt_q, rdData;
    logic [15:0] status_q;
    logic ack_q, setupDone_q, synthDone_q, crcFlag_q, skipFlag_q;
    logic firstRx_q, inPkt_q, prevErr_q, endReq_q, endStop_q;
    logic irqPend_q, wrEn, started, fail;
    logic [7:0] chan, maxLen;
    logic [1:0] role;
    logic [15:0] failCode;
    broc_rf_s rf_q;
    logic [7:0] ctrlW;

    // roles: 0 master, 1 slave, 2 advertising-type
    assign chan = param_q[7:0];
    assign role = param_q[9:8];

    // reset release through two flip-flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    assign rst = !rstSync_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // channel legality for the present role
    function automatic logic chanOk(input logic [7:0] c,
        input logic [1:0] r, input logic synthOn);
        if (c <= `BROC_ADV_MAX) begin
            if (r == 2'h2) begin
                return c >= `BROC_ADV_MIN;
            end
            return c <= `BROC_DATA_MAX;
        end
        if (c >= `BROC_DIR_MIN && c <= `BROC_DIR_MAX) begin
            return 1'b1;
        end
        if (c == `BROC_KEEP_CH) begin
            return synthOn;
        end
        return 1'b0;
    endfunction : chanOk

    // one wait state; a write lands on the edge that sees ack high
    assign wrEn = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end
    assign wb_ack_o = ack_q;
    assign ctrlW = (wrEn && wb_adr_i == `BROC_A_CTRL && wb_sel_i[0])
        ? wb_dat_i[7:0] : 8'h00;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            param_q <= `BROC_PARAM_RST;
            seed_q <= 32'h0000_0000;
            aaw_q <= 32'h0000_0000;
            start_q <= 32'h0000_0000;
            limit_q <= 32'h0000_0000;
        end else if (rst) begin
            param_q <= `BROC_PARAM_RST;
            seed_q <= 32'h0000_0000;
            aaw_q <= 32'h0000_0000;
            start_q <= 32'h0000_0000;
            limit_q <= 32'h0000_0000;
        end else if (wrEn) begin
            case (wb_adr_i)
                `BROC_A_PARAM: param_q <= merge(param_q, wb_dat_i, wb_sel_i);
                `BROC_A_SEED: seed_q <= merge(seed_q, wb_dat_i, wb_sel_i);
                `BROC_A_AAW: aaw_q <= merge(aaw_q, wb_dat_i, wb_sel_i);
                `BROC_A_START: start_q <= merge(start_q, wb_dat_i, wb_sel_i);
                `BROC_A_LIMIT: limit_q <= merge(limit_q, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    always_comb begin
        rdData = 32'h0000_0000;
        case (wb_adr_i)
            `BROC_A_PARAM: rdData = param_q;
            `BROC_A_SEED: rdData = seed_q;
            `BROC_A_AAW: rdData = aaw_q;
            `BROC_A_RXCFG: rdData = rxcfg_q;
            `BROC_A_START: rdData = start_q;
            `BROC_A_LIMIT: rdData = limit_q;
            `BROC_A_STAT: rdData = {12'h000, state_q != ST_IDLE,
                setupDone_q, skipFlag_q, crcFlag_q, status_q};
            `BROC_A_INFO: rdData = {11'h000, rf_q.directFreq,
                rf_q.freqMhz, rf_q.whitenEn, rf_q.whitenSeed};
            default: rdData = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= rdData;
        end
    end

    // mode setup and synth programming commands are remembered
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            setupDone_q <= 1'b0;
            synthDone_q <= 1'b0;
        end else if (rst) begin
            setupDone_q <= 1'b0;
            synthDone_q <= 1'b0;
        end else begin
            if (ctrlW[`BROC_C_SETUP]) begin
                setupDone_q <= 1'b1;
            end
            if (ctrlW[`BROC_C_SYNTH]) begin
                synthDone_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timeNow_q <= 32'h0000_0000;
        end else if (rst) begin
            timeNow_q <= 32'h0000_0000;
        end else begin
            timeNow_q <= timeNow_q + 32'h0000_0001;
        end
    end
    // signed distance so a moment already passed still starts
    always_comb begin
        case (param_q[11:10])
            2'h0: started = 1'b1;
            2'h1: started = $signed(timeNow_q - start_q) >= 0;
            2'h2: started = evtIn.startEvt;
            default: started = 1'b0;
        endcase
    end

    // datapath faults and the abort command during an operation
    always_comb begin
        fail = 1'b1;
        failCode = `BROC_S_ABORT;
        if (evtIn.rxOverflow) begin
            failCode = `BROC_S_RXOVF;
        end else if (evtIn.txUnderflow) begin
            failCode = `BROC_S_TXUNF;
        end else if (evtIn.genErr || ctrlW[`BROC_C_ABORT]) begin
            failCode = `BROC_S_ABORT;
        end else begin
            fail = 1'b0;
        end
    end

    assign maxLen = (role == 2'h2) ? rxcfg_q[15:8] : rxcfg_q[23:16];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            status_q <= `BROC_S_IDLE;
            waitCnt_q <= 32'h0000_0000;
            firstRx_q <= 1'b0;
            inPkt_q <= 1'b0;
            endReq_q <= 1'b0;
            endStop_q <= 1'b0;
            rf_q <= '0;
        end else if (rst) begin
            state_q <= ST_IDLE;
            status_q <= `BROC_S_IDLE;
            waitCnt_q <= 32'h0000_0000;
            firstRx_q <= 1'b0;
            inPkt_q <= 1'b0;
            endReq_q <= 1'b0;
            endStop_q <= 1'b0;
            rf_q <= '0;
        end else begin
            if (waitCnt_q != 32'h0000_0000) begin
                waitCnt_q <= waitCnt_q - 32'h0000_0001;
            end
            if (state_q inside {ST_RX, ST_RXEND, ST_TURNTX, ST_TX,
                ST_TURNRX}) begin
                if (evtIn.endEvt || ctrlW[`BROC_C_STOP]) begin
                    endReq_q <= 1'b1;
                    endStop_q <= ctrlW[`BROC_C_STOP];
                end
            end
            if (fail && state_q != ST_IDLE && state_q != ST_DONE) begin
                status_q <= failCode;
                state_q <= ST_DONE;
            end else begin
                case (state_q)
                    ST_IDLE: if (ctrlW[`BROC_C_SUBMIT]) begin
                        endReq_q <= 1'b0;
                        endStop_q <= 1'b0;
                        inPkt_q <= 1'b0;
                        if (!setupDone_q) begin
                            status_q <= `BROC_S_NOSETUP;
                            state_q <= ST_DONE;
                        end else begin
                            status_q <= `BROC_S_PEND;
                            state_q <= ST_PEND;
                        end
                    end
                    ST_PEND: if (started) begin
                        state_q <= ST_CHECK;
                    end
                    ST_CHECK: begin
                        status_q <= `BROC_S_ACTIVE;
                        state_q <= ST_PROG;
                        if (chan == `BROC_KEEP_CH
                            && !(evtIn.synthRunning && synthDone_q)) begin
                            status_q <= `BROC_S_NOFS;
                            state_q <= ST_DONE;
                        end else if (!chanOk(chan, role, 1'b1)) begin
                            status_q <= `BROC_S_PAR;
                            state_q <= ST_DONE;
                        end
                    end
                    ST_PROG: begin
                        if (chan != `BROC_KEEP_CH) begin
                            rf_q.chanIdx <= chan;
                            rf_q.directFreq <= chan >= `BROC_DIR_MIN;
                            rf_q.freqMhz <= `BROC_RF_BASE
                                + {4'h0, chan};
                        end
                        if (!param_q[13] && chan <= `BROC_ADV_MAX) begin
                            rf_q.whitenSeed <= `BROC_WH_BASE
                                | chan[6:0];
                            rf_q.whitenEn <= 1'b1;
                        end else begin
                            rf_q.whitenSeed <= param_q[22:16];
                            rf_q.whitenEn <= param_q[22:16] != 7'h00;
                        end
                        state_q <= ST_LOAD;
                    end
                    ST_LOAD: if (evtIn.synthFail) begin
                        status_q <= `BROC_S_SYNTH;
                        state_q <= ST_DONE;
                    end else begin
                        firstRx_q <= 1'b1;
                        state_q <= (role == 2'h0) ? ST_TX : ST_RX;
                        waitCnt_q <= (role == 2'h1 && param_q[12])
                            ? limit_q : `BROC_RXTO_CYC;
                    end
                    ST_RX: begin
                        if (rxIn.sync && !inPkt_q) begin
                            inPkt_q <= rxIn.len <= maxLen;
                        end else if (inPkt_q && rxIn.done) begin
                            inPkt_q <= 1'b0;
                            state_q <= ST_RXEND;
                        end else if (!inPkt_q
                            && waitCnt_q == 32'h0000_0000) begin
                            status_q <= firstRx_q && role == 2'h1
                                ? `BROC_S_RXTO : `BROC_S_NOSYNC;
                            state_q <= ST_DONE;
                        end
                    end
                    ST_RXEND: begin
                        firstRx_q <= 1'b0;
                        if (prevErr_q && !rxIn.crcOk) begin
                            status_q <= `BROC_S_RXERR;
                            state_q <= ST_DONE;
                        end else if (endReq_q && role != 2'h1) begin
                            status_q <= endStop_q ? `BROC_S_STOPPED
                                : `BROC_S_ENDED;
                            state_q <= ST_DONE;
                        end else begin
                            waitCnt_q <= `BROC_IFS_CYC;
                            state_q <= ST_TURNTX;
                        end
                    end
                    ST_TURNTX: if (waitCnt_q == 32'h0000_0001) begin
                        state_q <= ST_TX;
                    end
                    ST_TX: if (evtIn.txDone) begin
                        if (endReq_q && role == 2'h1) begin
                            status_q <= endStop_q ? `BROC_S_STOPPED
                                : `BROC_S_ENDED;
                            state_q <= ST_DONE;
                        end else begin
                            waitCnt_q <= `BROC_OPEN_CYC;
                            state_q <= ST_TURNRX;
                        end
                    end
                    ST_TURNRX: if (waitCnt_q == 32'h0000_0001) begin
                        waitCnt_q <= 32'(2 * `BROC_EARLY_CYC
                            + `BROC_RXTO_CYC);
                        state_q <= ST_RX;
                    end
                    ST_DONE: state_q <= ST_IDLE;
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // flags and sequence history of received packets
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            crcFlag_q <= 1'b0;
            skipFlag_q <= 1'b0;
            prevErr_q <= 1'b0;
            rxcfg_q <= `BROC_RXCFG_RST;
        end else if (rst) begin
            crcFlag_q <= 1'b0;
            skipFlag_q <= 1'b0;
            prevErr_q <= 1'b0;
            rxcfg_q <= `BROC_RXCFG_RST;
        end else begin
            if (wrEn && wb_adr_i == `BROC_A_RXCFG) begin
                rxcfg_q <= merge(rxcfg_q, wb_dat_i, wb_sel_i);
            end
            if (state_q == ST_LOAD) begin
                prevErr_q <= 1'b0;
            end
            if (state_q == ST_RXEND) begin
                crcFlag_q <= !rxIn.crcOk;
                skipFlag_q <= rxIn.crcOk
                    && rxIn.seqBit == rxcfg_q[24];
                prevErr_q <= !rxIn.crcOk;
                if (rxIn.crcOk && rxIn.bufFits) begin
                    rxcfg_q[24] <= rxIn.seqBit;
                end
            end
        end
    end

    // flush decided the cycle after the flags, interrupt in that same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flushEntry <= 1'b0;
            irqPend_q <= 1'b0;
            rxIrq <= 1'b0;
            storeEntry <= 1'b0;
            cmdDone <= 1'b0;
        end else if (rst) begin
            flushEntry <= 1'b0;
            irqPend_q <= 1'b0;
            rxIrq <= 1'b0;
            storeEntry <= 1'b0;
            cmdDone <= 1'b0;
        end else begin
            irqPend_q <= state_q == ST_RXEND;
            flushEntry <= irqPend_q && (
                (crcFlag_q && rxcfg_q[0])
                || (skipFlag_q && rxcfg_q[1])
                || (!crcFlag_q && !skipFlag_q && rxcfg_q[2]
                    && rxIn.len == 8'h00));
            rxIrq <= irqPend_q;
            storeEntry <= state_q == ST_RX && rxIn.sync && !inPkt_q
                && rxIn.len <= maxLen && rxIn.bufFits;
            cmdDone <= state_q == ST_DONE;
        end
    end

    assign rxEn = state_q == ST_RX;
    assign txEn = state_q == ST_TX;
    assign crcEnable = rxEn || txEn;
    assign synthProgram = state_q == ST_LOAD && chan != `BROC_KEEP_CH;
    assign loadLink = state_q == ST_LOAD;
    assign rfOut = rf_q;
    assign crcSeedOut = seed_q[23:0];
    assign accessWordOut = aaw_q;
    assign statusByte = {6'h00, skipFlag_q, crcFlag_q};
endmodule : broc_top

// ===== verification/broc_top_assertions.sv
// port checks of the radio operation control
`timescale 1ns/1ps
module broc_top_assertions
    import broc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // radio side
    input wire broc_rx_s rxIn,
    input wire broc_rf_s rfOut,
    input wire logic rxEn,
    input wire logic txEn,
    input wire logic crcEnable,
    input wire logic synthProgram,
    input wire logic loadLink,
    input wire logic storeEntry,
    input wire logic flushEntry,
    input wire logic rxIrq,
    input wire logic cmdDone
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i &&
        !wb_ack_o |=> wb_ack_o) else $error("bus request not answered");
    crc_radio_a: assert property (crcEnable == (rxEn || txEn))
        else $error("crc enable not tied to radio");
    radio_excl_a: assert property (!(rxEn && txEn))
        else $error("receive and transmit together");
    load_order_a: assert property (synthProgram |->
        loadLink && !rxEn && !txEn) else $error("load out of order");
    store_sync_a: assert property (storeEntry |->
        $past(rxIn.sync && rxIn.bufFits)) else $error("store without sync");
    long_drop_a: assert property (rxEn && rxIn.sync
        && rxIn.len > 8'h25 |=> !storeEntry)
        else $error("overlong packet stored");
    flush_irq_a: assert property (flushEntry |-> rxIrq)
        else $error("flush without interrupt");
    done_irq_a: assert property (rxEn && rxIn.done |-> ##[2:4] rxIrq)
        else $error("no interrupt after packet");
    direct_freq_a: assert property (rfOut.directFreq |->
        rfOut.freqMhz == 12'h8FC + rfOut.chanIdx) else $error("bad frequency");
    done_pulse_a: assert property (cmdDone |=> !cmdDone)
        else $error("done held high");
endmodule : broc_top_assertions
bind broc_top broc_top_assertions i_chk (.*);

// ===== verification/broc_radio_model.sv
// behavioural radio datapath answering the enables
`timescale 1ns/1ps
module broc_radio_model
    import broc_pkg::*;
(
    // clock
    input wire logic clock,
    // enables
    input wire logic rxEn,
    input wire logic txEn,
    // packet shape
    input wire logic [7:0] pktLen,
    input wire logic pktCrc,
    // events
    output broc_rx_s rxIn,
    output logic txDone
);
    initial begin
        rxIn = '0;
        forever begin
            @(posedge clock iff rxEn === 1'b1);
            repeat (10) @(posedge clock);
            rxIn.sync <= 1'b1;
            rxIn.len <= pktLen;
            rxIn.bufFits <= 1'b1;
            @(posedge clock);
            rxIn.sync <= 1'b0;
            // an overlong packet is cut off, so no done
            if (pktLen <= 8'h25) begin
                repeat (8) @(posedge clock);
                rxIn.done <= 1'b1;
                @(posedge clock);
                rxIn.done <= 1'b0;
                rxIn.crcOk <= pktCrc;
                repeat (4) @(posedge clock);
            end
            // stale fields turn to junk, never a held value
            rxIn.crcOk <= ~rxIn.crcOk;
            rxIn.len <= ~rxIn.len;
            rxIn.bufFits <= 1'b0;
            @(posedge clock iff rxEn !== 1'b1);
        end
    end
    initial begin
        txDone = 1'b0;
        forever begin
            @(posedge clock iff txEn === 1'b1);
            repeat (20) @(posedge clock);
            txDone <= 1'b1;
            @(posedge clock);
            txDone <= 1'b0;
            @(posedge clock iff txEn !== 1'b1);
        end
    end
endmodule : broc_radio_model

// ===== verification/broc_top_tb_top.sv
// self-checking bench of the radio operation control
`timescale 1ns/1ps
`include "broc_cfg.svh"
module broc_top_tb_top;
    import broc_pkg::*;
    logic clock = 1'b0, rstn = 1'b0, wbCyc = 1'b0, wbStb = 1'b0;
    logic wbWe = 1'b0, wbAck, pktCrc = 1'b0, rxEn, txEn, txDone;
    logic storeEntry, flushEntry, rxIrq;
    logic [7:0] wbAdr = 8'h00, pktLen = 8'h05;
    logic [31:0] wbDat = 32'h0, wbRd, rd;
    broc_rx_s rxIn;
    broc_evt_s ev = '0, evIn;
    int err_count = 0, compares = 0, nStore = 0, nFlush = 0, nIrq = 0;
    always #25 clock = ~clock;
    always_comb begin
        evIn = ev;
        evIn.txDone = txDone;
    end
    always @(posedge clock) begin
        nStore += (storeEntry === 1'b1);
        nFlush += (flushEntry === 1'b1);
        nIrq += (rxIrq === 1'b1);
    end
    broc_top i_dut (.clock(clock), .rstn(rstn), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(4'hF), .wb_dat_i(wbDat), .wb_dat_o(wbRd),
        .wb_ack_o(wbAck), .rxIn(rxIn), .evtIn(evIn), .rxEn(rxEn),
        .txEn(txEn), .crcEnable(), .synthProgram(), .loadLink(),
        .rfOut(), .crcSeedOut(), .accessWordOut(),
        .storeEntry(storeEntry), .flushEntry(flushEntry),
        .statusByte(), .rxIrq(rxIrq), .cmdDone());
    broc_radio_model i_model (.clock(clock), .rxEn(rxEn), .txEn(txEn),
        .pktLen(pktLen), .pktCrc(pktCrc), .rxIn(rxIn), .txDone(txDone));
    task automatic end_sim;
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbRd;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        chk("bus ack", n < 20, 1'b1);
        if (n >= 20) end_sim();
        @(posedge clock);
    endtask : wb
    // polls status; a long run of reads stands in for the timeout
    task automatic waitStat(input logic [15:0] e);
        int n;
        n = 0;
        do begin
            wb(1'b0, `BROC_A_STAT, 32'h0);
            n++;
        end while (rd[15:0] !== e && n < 8000);
        chk("status", rd[15:0], e);
        if (rd[15:0] !== e) end_sim();
    endtask : waitStat
    task automatic t_reset;
        wb(1'b0, `BROC_A_STAT, 32'h0);
        chk("reset status", rd[15:0], 16'h0000);
        wb(1'b0, `BROC_A_RXCFG, 32'h0);
        chk("rx config", rd, 32'h011F_2500);
    endtask : t_reset
    task automatic t_submit(input logic [31:0] p, input logic [15:0] e);
        wb(1'b1, `BROC_A_PARAM, p);
        wb(1'b1, `BROC_A_CTRL, 32'h1);
        waitStat(e);
    endtask : t_submit
    task automatic t_master;
        wb(1'b1, `BROC_A_RXCFG, 32'h011F_2501);
        wb(1'b1, `BROC_A_PARAM, 32'h0000_0805);
        wb(1'b1, `BROC_A_CTRL, 32'h1);
        wb(1'b0, `BROC_A_STAT, 32'h0);
        chk("pending", rd[15:0], 16'h0001);
        chk("radio idle", rxEn | txEn, 1'b0);
        ev.startEvt <= 1'b1;
        @(posedge clock);
        ev.startEvt <= 1'b0;
        waitStat(16'h0002);
        wb(1'b0, `BROC_A_INFO, 32'h0);
        chk("whiten seed", rd[7:0], 8'hC5);
        waitStat(16'h1403);
        chk("crc flag", rd[16], 1'b1);
        chk("irqs", nIrq, 2);
        chk("flushes", nFlush, 2);
        chk("stores", nStore, 2);
    endtask : t_master
    task automatic t_direct;
        t_submit(32'h0000_2464, 16'h0002);
        wb(1'b0, `BROC_A_INFO, 32'h0);
        chk("direct info", rd, 32'h0019_6000);
        ev.rxOverflow <= 1'b1;
        @(posedge clock);
        ev.rxOverflow <= 1'b0;
        waitStat(16'h1805);
    endtask : t_direct
    task automatic t_slave;
        pktLen <= 8'h30;
        wb(1'b1, `BROC_A_LIMIT, 32'd300);
        t_submit(32'h0000_1103, 16'h1401);
        chk("overlong stores", nStore, 2);
    endtask : t_slave
    task automatic t_abort;
        wb(1'b1, `BROC_A_PARAM, 32'h0000_0805);
        wb(1'b1, `BROC_A_CTRL, 32'h1);
        wb(1'b1, `BROC_A_CTRL, 32'h2);
        waitStat(16'h1407);
    endtask : t_abort
    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        t_reset();
        t_submit(32'h0000_0005, 16'h1802);
        wb(1'b1, `BROC_A_CTRL, 32'h8);
        t_submit(32'h0000_0025, 16'h1800);
        t_master();
        t_direct();
        t_slave();
        t_submit(32'h0000_00FF, 16'h1803);
        t_abort();
        end_sim();
    end
endmodule : broc_top_tb_top
